// File: ext_cap_pkg.sv
// Operation
// - capture header dword 1 of the first reported uncorrectable error, read-only
// - capture header dwords 2 to 4 of that packet into three read-only logs
// - serial number capability header reads identifier 0x3 in bits 15:0
// - both capability headers read version 0x1 in bits 19:16
// - virtual channel header next pointer, bits 31:20, lock-writable, resets to zero
// - 64-bit unique id as two lock-writable words, low half at lower offset
// - virtual channel capability header reads identifier 0x2 in its low field
// - extra virtual channel count, bits 2:0, reads zero
// - low priority extra virtual channel count, bits 6:4, reads zero
// - arbitration time base, bits 9:8, reads zero
// - port arbitration entry width reads 0x2 upstream, 0x0 downstream
// - entry width codes: 0 1-bit, 1 2-bit, 2 4-bit, 3 8-bit
// - low serial number word resets to zero and is sticky
package ext_cap_pkg;

  localparam int ADDR_W = 12;

  localparam logic [ADDR_W-1:0] OFF_HL1    = 12'h11C;
  localparam logic [ADDR_W-1:0] OFF_HL2    = 12'h120;
  localparam logic [ADDR_W-1:0] OFF_HL3    = 12'h124;
  localparam logic [ADDR_W-1:0] OFF_HL4    = 12'h128;
  localparam logic [ADDR_W-1:0] OFF_SN_CAP = 12'h180;
  localparam logic [ADDR_W-1:0] OFF_SN_LO  = 12'h184;
  localparam logic [ADDR_W-1:0] OFF_SN_HI  = 12'h188;
  localparam logic [ADDR_W-1:0] OFF_VC_CAP = 12'h200;
  localparam logic [ADDR_W-1:0] OFF_PVC1   = 12'h204;

  localparam int ID_LSB      = 0;
  localparam int VER_LSB     = 16;
  localparam int PTR_LSB     = 20;
  localparam int PTR_W       = 12;
  localparam int EXTRA_LSB   = 0;
  localparam int LOWPRI_LSB  = 4;
  localparam int ARBTB_LSB   = 8;
  localparam int ENTRY_LSB   = 10;

  localparam logic [15:0]      SN_CAP_ID      = 16'h0003;
  localparam logic [15:0]      VC_CAP_ID      = 16'h0002;
  localparam logic [3:0]       CAP_VERSION    = 4'h1;
  localparam logic [PTR_W-1:0] NEXT_PTR_RESET = 12'h000;
  localparam logic [31:0]      SN_LO_RESET    = 32'h0000_0000;
  localparam logic [31:0]      LOG_RESET      = 32'h0000_0000;
  localparam logic [2:0]       EXTRA_VC_COUNT = 3'h0;
  localparam logic [2:0]       LOWPRI_VC_COUNT = 3'h0;
  localparam logic [1:0]       ARB_TIME_BASE  = 2'h0;

  typedef enum logic [1:0] {
    ENTRY_1BIT = 2'h0,
    ENTRY_2BIT = 2'h1,
    ENTRY_4BIT = 2'h2,
    ENTRY_8BIT = 2'h3
  } arb_entry_width_t;

  localparam arb_entry_width_t UP_ENTRY   = ENTRY_4BIT;
  localparam arb_entry_width_t DOWN_ENTRY = ENTRY_1BIT;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_HL1, SEL_HL2, SEL_HL3, SEL_HL4,
    SEL_SN_CAP, SEL_SN_LO, SEL_SN_HI, SEL_VC_CAP, SEL_PVC1
  } reg_sel_t;

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] a;
    a = {addr[ADDR_W-1:2], 2'h0};
    case (a)
      OFF_HL1:    decode = SEL_HL1;
      OFF_HL2:    decode = SEL_HL2;
      OFF_HL3:    decode = SEL_HL3;
      OFF_HL4:    decode = SEL_HL4;
      OFF_SN_CAP: decode = SEL_SN_CAP;
      OFF_SN_LO:  decode = SEL_SN_LO;
      OFF_SN_HI:  decode = SEL_SN_HI;
      OFF_VC_CAP: decode = SEL_VC_CAP;
      OFF_PVC1:   decode = SEL_PVC1;
      default:    decode = SEL_NONE;
    endcase
  endfunction : decode

  function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      strobe_mask[i*8 +: 8] = {8{strb[i]}};
    end
  endfunction : strobe_mask

  function automatic logic [31:0] cap_header(input logic [15:0] id,
                                             input logic [PTR_W-1:0] ptr);
    cap_header = 32'h0000_0000;
    cap_header[ID_LSB +: 16] = id;
    cap_header[VER_LSB +: 4] = CAP_VERSION;
    cap_header[PTR_LSB +: PTR_W] = ptr;
  endfunction : cap_header

  function automatic logic [31:0] pvc1_word(input logic upstream);
    pvc1_word = 32'h0000_0000;
    pvc1_word[EXTRA_LSB +: 3] = EXTRA_VC_COUNT;
    pvc1_word[LOWPRI_LSB +: 3] = LOWPRI_VC_COUNT;
    pvc1_word[ARBTB_LSB +: 2] = ARB_TIME_BASE;
    pvc1_word[ENTRY_LSB +: 2] = upstream ? UP_ENTRY : DOWN_ENTRY;
  endfunction : pvc1_word

endpackage : ext_cap_pkg

// File: lock_word_reg.sv
module lock_word_reg #(
  parameter int               WIDTH     = 32,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             aclk,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic             locked,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [WIDTH-1:0] wr_mask,
  output logic      [WIDTH-1:0] value
);
  import ext_cap_pkg::*;

  wire             take = wr_en & ~locked;
  wire [WIDTH-1:0] value_next = (value & ~wr_mask) | (wr_data & wr_mask);

  if (WIDTH < 1 || WIDTH > 32) begin : g_chk
    $error("lock_word_reg width out of range");
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      value <= RESET_VAL;
    end else if (take) begin
      value <= value_next;
    end
  end

  lock_hold_a: assert property (@(posedge aclk) disable iff (!rst_n)
    wr_en && locked |=> $stable(value))
    else $error("locked field changed");

endmodule : lock_word_reg

// File: header_log_capture.sv
module header_log_capture (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        log_capture,
  input  wire logic        log_rearm,
  input  wire logic [31:0] header_word1,
  input  wire logic [31:0] header_word2,
  input  wire logic [31:0] header_word3,
  input  wire logic [31:0] header_word4,
  output logic      [31:0] log_word1,
  output logic      [31:0] log_word2,
  output logic      [31:0] log_word3,
  output logic      [31:0] log_word4,
  output logic             log_held
);
  import ext_cap_pkg::*;

  // only the first reported error is logged until the log is re-armed
  wire first = log_capture & (~log_held | log_rearm);
  // a capture in the re-arm cycle still lands and keeps the log held
  wire held_next = first | (log_held & ~log_rearm);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      log_held <= 1'b0;
      log_word1 <= LOG_RESET;
      log_word2 <= LOG_RESET;
      log_word3 <= LOG_RESET;
      log_word4 <= LOG_RESET;
    end else begin
      log_held <= held_next;
      if (first) begin
        log_word1 <= header_word1;
        log_word2 <= header_word2;
        log_word3 <= header_word3;
        log_word4 <= header_word4;
      end
    end
  end

  first_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    first |=> log_word2 == $past(header_word2) && log_word4 == $past(header_word4)
              && log_word1 == $past(header_word1) && log_held)
    else $error("first error header not captured");

  log_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    log_held && !(log_rearm && log_capture) |=> $stable(log_word1) && $stable(log_word3))
    else $error("held header log overwritten");

endmodule : header_log_capture

// File: ext_capability_regs.sv
module ext_capability_regs #(
  parameter logic [31:0] SN_HI_RESET = 32'h0000_0000
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          sticky_resetn,
  input  wire logic                          port_is_upstream,
  input  wire logic                          cfg_write_lock,
  input  wire logic                          log_capture,
  input  wire logic                          log_rearm,
  input  wire logic [31:0]                   header_word1,
  input  wire logic [31:0]                   header_word2,
  input  wire logic [31:0]                   header_word3,
  input  wire logic [31:0]                   header_word4,
  input  wire logic [ext_cap_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [ext_cap_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [63:0]                        unique_id_value
);
  import ext_cap_pkg::*;

  logic                  aw_held_reg;
  logic                  w_held_reg;
  logic [ADDR_W-1:0]     awaddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic [PTR_W-1:0]      sn_ptr;
  logic [PTR_W-1:0]      vc_ptr;
  logic [31:0]           sn_lo;
  logic [31:0]           sn_hi;
  logic [31:0]           hl1;
  logic [31:0]           hl2;
  logic [31:0]           hl3;
  logic [31:0]           hl4;

  // write channel: address and data taken in either order, answered once both are in
  wire aw_fire  = s_axi_awvalid & s_axi_awready;
  wire w_fire   = s_axi_wvalid & s_axi_wready;
  wire wr_go    = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire b_fire   = s_axi_bvalid & s_axi_bready;
  wire aw_held_next = aw_fire | (aw_held_reg & ~wr_go);
  wire w_held_next  = w_fire | (w_held_reg & ~wr_go);
  wire bvalid_next  = wr_go | (s_axi_bvalid & ~b_fire);
  wire awready_next = ~aw_held_next & ~bvalid_next;
  wire wready_next  = ~w_held_next & ~bvalid_next;

  wire reg_sel_t wr_sel = decode(awaddr_reg);
  wire [31:0]    wr_mask = strobe_mask(wstrb_reg);
  // writes are gated by the core reset so sticky state survives it
  wire           wr_en   = wr_go & aresetn;
  // read-only and reserved bits simply have no write path
  wire           wr_ok   = wr_sel != SEL_NONE;
  wire [1:0]     bresp_next = wr_ok ? RESP_OKAY : RESP_SLVERR;

  wire wr_sn_cap = wr_en & (wr_sel == SEL_SN_CAP);
  wire wr_sn_lo  = wr_en & (wr_sel == SEL_SN_LO);
  wire wr_sn_hi  = wr_en & (wr_sel == SEL_SN_HI);
  wire wr_vc_cap = wr_en & (wr_sel == SEL_VC_CAP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_held_reg   <= aw_held_next;
      w_held_reg    <= w_held_next;
      s_axi_awready <= awready_next;
      s_axi_wready  <= wready_next;
      s_axi_bvalid  <= bvalid_next;
      if (wr_go) begin
        s_axi_bresp <= bresp_next;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= '0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else begin
      if (aw_fire) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // lock-writable fields
  lock_word_reg #(.WIDTH(PTR_W), .RESET_VAL(NEXT_PTR_RESET)) u_sn_ptr (
    .aclk    (aclk),
    .rst_n   (aresetn),
    .wr_en   (wr_sn_cap),
    .locked  (cfg_write_lock),
    .wr_data (wdata_reg[PTR_LSB +: PTR_W]),
    .wr_mask (wr_mask[PTR_LSB +: PTR_W]),
    .value   (sn_ptr)
  );

  lock_word_reg #(.WIDTH(PTR_W), .RESET_VAL(NEXT_PTR_RESET)) u_vc_ptr (
    .aclk    (aclk),
    .rst_n   (aresetn),
    .wr_en   (wr_vc_cap),
    .locked  (cfg_write_lock),
    .wr_data (wdata_reg[PTR_LSB +: PTR_W]),
    .wr_mask (wr_mask[PTR_LSB +: PTR_W]),
    .value   (vc_ptr)
  );

  // low serial word only answers the sticky reset
  lock_word_reg #(.WIDTH(32), .RESET_VAL(SN_LO_RESET)) u_sn_lo (
    .aclk    (aclk),
    .rst_n   (sticky_resetn),
    .wr_en   (wr_sn_lo),
    .locked  (cfg_write_lock),
    .wr_data (wdata_reg),
    .wr_mask (wr_mask),
    .value   (sn_lo)
  );

  lock_word_reg #(.WIDTH(32), .RESET_VAL(SN_HI_RESET)) u_sn_hi (
    .aclk    (aclk),
    .rst_n   (aresetn),
    .wr_en   (wr_sn_hi),
    .locked  (cfg_write_lock),
    .wr_data (wdata_reg),
    .wr_mask (wr_mask),
    .value   (sn_hi)
  );

  header_log_capture u_log (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .log_capture  (log_capture),
    .log_rearm    (log_rearm),
    .header_word1 (header_word1),
    .header_word2 (header_word2),
    .header_word3 (header_word3),
    .header_word4 (header_word4),
    .log_word1    (hl1),
    .log_word2    (hl2),
    .log_word3    (hl3),
    .log_word4    (hl4),
    .log_held     ()
  );

  always_ff @(posedge aclk) begin
    unique_id_value <= {sn_hi, sn_lo};
  end

  // read channel: one word per request, data one cycle after the address
  wire ar_fire     = s_axi_arvalid & s_axi_arready;
  wire r_fire      = s_axi_rvalid & s_axi_rready;
  wire rvalid_next = ar_fire | (s_axi_rvalid & ~r_fire);
  wire arready_next = ~rvalid_next;

  wire reg_sel_t rd_sel = decode(s_axi_araddr);
  wire [31:0] sn_cap_word = cap_header(SN_CAP_ID, sn_ptr);
  wire [31:0] vc_cap_word = cap_header(VC_CAP_ID, vc_ptr);
  wire [31:0] pvc1_now    = pvc1_word(port_is_upstream);
  wire [31:0] rd_word =
      (rd_sel == SEL_HL1)    ? hl1 :
      (rd_sel == SEL_HL2)    ? hl2 :
      (rd_sel == SEL_HL3)    ? hl3 :
      (rd_sel == SEL_HL4)    ? hl4 :
      (rd_sel == SEL_SN_CAP) ? sn_cap_word :
      (rd_sel == SEL_SN_LO)  ? sn_lo :
      (rd_sel == SEL_SN_HI)  ? sn_hi :
      (rd_sel == SEL_VC_CAP) ? vc_cap_word :
      (rd_sel == SEL_PVC1)   ? pvc1_now : 32'h0000_0000;
  wire [1:0] rresp_next = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= arready_next;
      s_axi_rvalid  <= rvalid_next;
      if (ar_fire) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rresp_next;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sn_header_a: assert property (ar_fire && rd_sel == SEL_SN_CAP |=>
    s_axi_rvalid && s_axi_rdata[15:0] == 16'h0003 && s_axi_rdata[19:16] == 4'h1)
    else $error("serial header id or version wrong");

  vc_header_a: assert property (ar_fire && rd_sel == SEL_VC_CAP |=>
    s_axi_rdata[15:0] == 16'h0002 && s_axi_rdata[19:16] == 4'h1
    && s_axi_rdata[31:20] == $past(vc_ptr))
    else $error("vc header id, version or pointer wrong");

  pvc_fields_a: assert property (ar_fire && rd_sel == SEL_PVC1 |=>
    s_axi_rdata == ($past(port_is_upstream) ? 32'h0000_0800 : 32'h0000_0000))
    else $error("port vc capability word wrong");

  sn_write_a: assert property (wr_sn_lo && !cfg_write_lock && wstrb_reg == 4'hF |=>
    sn_lo == $past(wdata_reg) && unique_id_value[31:0] == $past(sn_lo))
    else $error("unlocked serial write lost");

  sn_locked_a: assert property (wr_sn_hi && cfg_write_lock |=>
    $stable(sn_hi) ##1 unique_id_value[63:32] == $past(sn_hi, 2))
    else $error("locked serial word changed");

  log_ro_a: assert property (wr_go && wr_sel == SEL_HL2 && !log_capture |=>
    $stable(hl2) && s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("header log written by software");

  sticky_keep_a: assert property (@(posedge aclk) disable iff (!sticky_resetn)
    !aresetn |=> $stable(sn_lo))
    else $error("sticky serial word lost on core reset");

  wr_answer_a: assert property (aw_fire && w_fire && !s_axi_bvalid |=> ##1
    s_axi_bvalid && s_axi_bresp == ((decode($past(s_axi_awaddr, 2)) == SEL_NONE)
      ? RESP_SLVERR : RESP_OKAY))
    else $error("write answer late or wrong");

  rd_answer_a: assert property (ar_fire |=> s_axi_rvalid && !s_axi_arready
    ##0 (s_axi_rvalid && !s_axi_rready) [*1] |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");

  sn_write_c: cover property (wr_sn_lo && !cfg_write_lock);
  locked_write_c: cover property (wr_sn_cap && cfg_write_lock);
  pvc_read_c: cover property (ar_fire && rd_sel == SEL_PVC1 && port_is_upstream);
  bad_addr_c: cover property (ar_fire && rd_sel == SEL_NONE);

endmodule : ext_capability_regs

// File: tb_top.sv
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ext_cap_pkg::*;

  // arbitrary reset value of the high serial word
  localparam logic [31:0] HI_RST = 32'h0000_00A5;

  typedef struct packed {
    logic [11:0] a;
    logic [31:0] wd;
    logic [3:0]  st;
    logic [31:0] rd;
    logic [1:0]  br;
    logic [1:0]  rr;
  } row_t;

  logic        aclk, aresetn, sticky_resetn, port_is_upstream, cfg_write_lock;
  logic        log_capture, log_rearm;
  logic [31:0] header_word1, header_word2, header_word3, header_word4;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [63:0] unique_id_value;
  int          miscompares = 0;
  int          checks = 0;
  logic [31:0] rdv;
  logic [1:0]  rsp;

  row_t rows [11] = '{
    '{12'h120, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, RESP_OKAY, RESP_OKAY},
    '{12'h124, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, RESP_OKAY, RESP_OKAY},
    '{12'h128, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, RESP_OKAY, RESP_OKAY},
    '{12'h11C, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, RESP_OKAY, RESP_OKAY},
    '{12'h204, 32'hFFFF_FFFF, 4'hF, 32'h0000_0800, RESP_OKAY, RESP_OKAY},
    '{12'h180, 32'hFFFF_FFFF, 4'hF, 32'hFFF1_0003, RESP_OKAY, RESP_OKAY},
    '{12'h200, 32'h0AB0_0000, 4'hF, 32'h0AB1_0002, RESP_OKAY, RESP_OKAY},
    '{12'h184, 32'h1234_5678, 4'hF, 32'h1234_5678, RESP_OKAY, RESP_OKAY},
    '{12'h188, 32'h9ABC_DEF0, 4'hF, 32'h9ABC_DEF0, RESP_OKAY, RESP_OKAY},
    '{12'h300, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000, RESP_SLVERR, RESP_SLVERR},
    '{12'h200, 32'hFF5F_FFFF, 4'h4, 32'h0A51_0002, RESP_OKAY, RESP_OKAY}
  };

  ext_capability_regs #(.SN_HI_RESET(HI_RST)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .sticky_resetn(sticky_resetn),
    .port_is_upstream(port_is_upstream), .cfg_write_lock(cfg_write_lock),
    .log_capture(log_capture), .log_rearm(log_rearm),
    .header_word1(header_word1), .header_word2(header_word2),
    .header_word3(header_word3), .header_word4(header_word4),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .unique_id_value(unique_id_value)
  );

  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  task automatic final_report;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic bound_hit;
    miscompares++;
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, 1'h0, 1'h1);
    final_report();
  endtask : bound_hit

  // all bus tasks start and end just after a rising edge
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int  n;
    logic aw_ok, w_ok;
    n = 0;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok) && n < 200) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (!(aw_ok && w_ok && s_axi_bvalid) && n < 200) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 200) bound_hit();
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : axi_write

  // lag holds rready low for that many edges to make the slave keep its answer
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r,
                          input int lag = 0);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= (lag == 0);
    do begin
      @(posedge aclk);
      n++;
    end while (!(s_axi_arvalid && s_axi_arready) && n < 200);
    s_axi_arvalid <= 1'h0;
    do begin
      @(posedge aclk);
      n++;
      if (n > lag) s_axi_rready <= 1'h1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
    if (n >= 200) bound_hit();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : axi_read

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    axi_read(a, rdv, rsp);
    `CHK(rdv, e)
    `CHK(rsp, RESP_OKAY)
  endtask : rd_chk

  task automatic capture(input logic [31:0] base, input logic rearm = 1'h0);
    header_word1 <= base;
    header_word2 <= base + 32'h0000_0011;
    header_word3 <= base + 32'h0000_0022;
    header_word4 <= base + 32'h0000_0033;
    log_rearm <= rearm;
    log_capture <= 1'h1;
    @(posedge aclk);
    log_capture <= 1'h0;
    log_rearm <= 1'h0;
    @(posedge aclk);
  endtask : capture

  task automatic log_chk(input logic [31:0] base);
    rd_chk(12'h11C, base);
    rd_chk(12'h120, base + 32'h0000_0011);
    rd_chk(12'h124, base + 32'h0000_0022);
    rd_chk(12'h128, base + 32'h0000_0033);
  endtask : log_chk

  task automatic core_reset;
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
  endtask : core_reset

  initial begin
    {aresetn, sticky_resetn, cfg_write_lock, log_capture, log_rearm} = '0;
    port_is_upstream = 1'h1;
    {header_word1, header_word2, header_word3, header_word4} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    sticky_resetn <= 1'h1;
    repeat (2) @(posedge aclk);
    foreach (rows[i]) begin
      axi_write(rows[i].a, rows[i].wd, rows[i].st, rsp);
      `CHK(rsp, rows[i].br)
      axi_read(rows[i].a, rdv, rsp);
      `CHK(rdv, rows[i].rd)
      `CHK(rsp, rows[i].rr)
    end
    `CHK(unique_id_value, 64'h9ABC_DEF0_1234_5678)
    axi_read(12'h188, rdv, rsp, 3);
    `CHK(rdv, 32'h9ABC_DEF0)
    $display("test rows done");
    cfg_write_lock <= 1'h1;
    axi_write(12'h184, 32'hFFFF_FFFF, 4'hF, rsp);
    `CHK(rsp, RESP_OKAY)
    axi_write(12'h200, 32'hFFFF_FFFF, 4'hF, rsp);
    axi_write(12'h180, 32'h0120_0000, 4'hF, rsp);
    axi_write(12'h188, 32'h0000_0000, 4'hF, rsp);
    `CHK(rsp, RESP_OKAY)
    rd_chk(12'h188, 32'h9ABC_DEF0);
    rd_chk(12'h184, 32'h1234_5678);
    rd_chk(12'h200, 32'h0A51_0002);
    rd_chk(12'h180, 32'hFFF1_0003);
    cfg_write_lock <= 1'h0;
    $display("test lock done");
    core_reset();
    rd_chk(12'h184, 32'h1234_5678);
    rd_chk(12'h188, HI_RST);
    rd_chk(12'h200, 32'h0001_0002);
    rd_chk(12'h180, 32'h0001_0003);
    sticky_resetn <= 1'h0;
    repeat (2) @(posedge aclk);
    sticky_resetn <= 1'h1;
    @(posedge aclk);
    rd_chk(12'h184, 32'h0000_0000);
    $display("test sticky done");
    capture(32'hA000_0100);
    log_chk(32'hA000_0100);
    capture(32'hB000_0200);
    log_chk(32'hA000_0100);
    log_rearm <= 1'h1;
    @(posedge aclk);
    capture(32'hC000_0300);
    log_chk(32'hC000_0300);
    axi_write(12'h124, 32'h0000_0000, 4'hF, rsp);
    rd_chk(12'h124, 32'hC000_0322);
    capture(32'hD000_0400, 1'h1);
    log_chk(32'hD000_0400);
    capture(32'hE000_0500);
    log_chk(32'hD000_0400);
    $display("test log done");
    port_is_upstream <= 1'h0;
    @(posedge aclk);
    rd_chk(12'h204, 32'h0000_0000);
    $display("test downstream done");
    final_report();
  end
endmodule : tb_top
